// ===== src/frs_ramp_seq.sv
// FMCW ramp sequencer with Wishbone register file
//
// Chosen here: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "frs_regs.svh"
//
// Contract
// - Enabled ramp adds shifted deviation per tick
// - Single ramp burst holds final value
// - Single triangle subtracts deviation after up-steps; the code has no single triangle mode, code 10 is single sawtooth
// - Single sawtooth restores start then holds
// - Continuous sawtooth repeats until disabled
// - Continuous triangle alternates equal up/down phases
// - Fraction carries 25 bits
// - 16-bit deviation scaled by 4-bit shift
// - Interval is first times second divider
// - Code 01 continuous triangle, 11 single ramp
// - Dual bit enables two rate sets; code alternates them only at continuous triangle turns
// - Deviation write goes to selected set
// - Step write goes to selected set
// - Other set reprogrammable while running
// - FSK bit superimposes deviation on ramp
// - With FSK, set two is FSK deviation
// - Transmit pin selects plus or minus FSK
// - Delayed start by word or word times first
module frs_ramp_seq
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [5:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Transmit data pin
  input wire logic tx_data_i,
  // Divider value to sigma-delta divider
  output logic [36:0] divider_o,
  output logic ramp_busy_o
);
  // Register storage
  logic [31:0] frac_int_word;
  logic [31:0] low_fraction_word;
  logic [31:0] reference_divider_word;
  logic [31:0] function_word;
  logic [31:0] clock_word;
  logic [31:0] delay_config_word;
  logic [15:0] dev_set [2];
  logic [3:0] shift_set [2];
  logic [19:0] steps_set [2];
  logic dual_en;
  logic fsk_en;
  // Sequencer state
  frs_pkg::frs_state_t state;
  logic [36:0] ramp_val;
  logic [36:0] start_val;
  logic [19:0] step_cnt;
  logic [11:0] delay_cnt;
  logic cur_set;
  logic tx_meta;
  logic tx_sync;

  // Bus decode
  wire logic wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire logic wb_wr = wb_req && wb_we_i && (wb_sel_i == 4'hf);
  wire logic [3:0] idx = wb_adr_i[5:2];
  wire logic wr_dev = wb_wr && (idx == {1'b0, `FRS_IDX_DEVIATION});
  wire logic wr_step = wb_wr && (idx == {1'b0, `FRS_IDX_STEP});
  wire logic wr_start = wb_wr && (idx == {1'b0, `FRS_IDX_FRAC_INT});
  wire logic dsel = wb_dat_i[`FRS_SET_SEL_BIT];

  // Divider value assembled from integer and both fraction parts
  wire logic [11:0] int_part = frac_int_word[`FRS_INT_MSB:`FRS_INT_LSB];
  wire logic [24:0] frac_part = {frac_int_word[`FRS_FMSB_MSB:`FRS_FMSB_LSB],
    low_fraction_word[`FRS_FLSB_MSB:`FRS_FLSB_LSB]};
  wire logic [36:0] base_val = {int_part, frac_part};
  // Start write takes integer and upper fraction from the bus word; the register is still old
  wire logic [36:0] load_val = wr_start ? {wb_dat_i[`FRS_INT_MSB:`FRS_INT_LSB],
    wb_dat_i[`FRS_FMSB_MSB:`FRS_FMSB_LSB],
    low_fraction_word[`FRS_FLSB_MSB:`FRS_FLSB_LSB]} : base_val;
  wire logic ramp_on = frac_int_word[`FRS_RAMP_ON_BIT];
  wire frs_pkg::frs_wave_t wave =
    frs_pkg::frs_wave_t'(function_word[`FRS_WAVE_MSB:`FRS_WAVE_LSB]);

  // Timer dividers; second divider only when selected as ramp divider
  wire logic [11:0] first_div = reference_divider_word[`FRS_FIRST_TIMER_DIVIDER_MSB:`FRS_FIRST_TIMER_DIVIDER_LSB];
  wire logic sel_ramp =
    clock_word[`FRS_CLKSEL_MSB:`FRS_CLKSEL_LSB] == `FRS_CLKSEL_RAMP;
  wire logic [11:0] second_div =
    sel_ramp ? clock_word[`FRS_SECOND_TIMER_DIVIDER_MSB:`FRS_SECOND_TIMER_DIVIDER_LSB] : 12'h001;

  // Active rate set: ramp always uses set 0 under FSK
  wire logic use_set = dual_en && !fsk_en && cur_set;
  wire logic [36:0] step_amt =
    {21'h000000, dev_set[use_set]} << shift_set[use_set];
  wire logic [19:0] step_lim = steps_set[use_set];
  wire logic last_step = (step_cnt + 20'h00001 >= step_lim);
  wire logic [36:0] fsk_amt = {21'h000000, dev_set[1]} << shift_set[1];
  wire logic running = (state != frs_pkg::FRS_IDLE);
  wire logic seq_run = running && ramp_on;
  wire logic first_tick;
  wire logic tick;

  // Delay length in base units
  wire logic dly_en = delay_config_word[`FRS_DLY_EN_BIT];
  wire logic dly_by_first = delay_config_word[`FRS_DLY_FIRST_TIMER_DIVIDER_BIT];
  wire logic dly_unit = dly_by_first ? first_tick : 1'b1;
  wire logic [11:0] dly_word = delay_config_word[`FRS_DLY_MSB:`FRS_DLY_LSB];

  // FSK superimposed on the current ramp value
  wire logic [36:0] next_divider = !fsk_en ? ramp_val :
    (tx_sync ? ramp_val + fsk_amt : ramp_val - fsk_amt);

  frs_timer u_timer
  (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .run_i(seq_run && state != frs_pkg::FRS_HOLD),
    .first_div_i(first_div),
    .second_div_i(second_div),
    .first_tick_o(first_tick),
    .tick_o(tick)
  );

  // Bus answer, one wait-free ack cycle after the request
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end
    else
    begin
      wb_ack_o <= wb_req;
      case (idx)
        {1'b0, `FRS_IDX_FRAC_INT}: wb_dat_o <= frac_int_word;
        {1'b0, `FRS_IDX_LOW_FRAC}: wb_dat_o <= low_fraction_word;
        {1'b0, `FRS_IDX_REF_DIV}: wb_dat_o <= reference_divider_word;
        {1'b0, `FRS_IDX_FUNCTION}: wb_dat_o <= function_word;
        {1'b0, `FRS_IDX_CLOCK}: wb_dat_o <= clock_word;
        {1'b0, `FRS_IDX_DELAY}: wb_dat_o <= delay_config_word;
        `FRS_IDX_STATUS: wb_dat_o <= {28'h0000000, running, 3'(state)};
        default: wb_dat_o <= 32'h00000000;
      endcase
    end
  end

  // Plain configuration words
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      frac_int_word <= 32'h00000000;
      low_fraction_word <= 32'h00000000;
      reference_divider_word <= 32'h00000000;
      function_word <= 32'h00000000;
      clock_word <= 32'h00000000;
      delay_config_word <= 32'h00000000;
    end
    else if (wb_wr)
    begin
      case (idx)
        {1'b0, `FRS_IDX_FRAC_INT}: frac_int_word <= wb_dat_i;
        {1'b0, `FRS_IDX_LOW_FRAC}: low_fraction_word <= wb_dat_i;
        {1'b0, `FRS_IDX_REF_DIV}: reference_divider_word <= wb_dat_i;
        {1'b0, `FRS_IDX_FUNCTION}: function_word <= wb_dat_i;
        {1'b0, `FRS_IDX_CLOCK}: clock_word <= wb_dat_i;
        {1'b0, `FRS_IDX_DELAY}: delay_config_word <= wb_dat_i;
        default: ;
      endcase
    end
  end

  // Rate sets; the idle set may change mid-ramp without disturbing it
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      dev_set[0] <= 16'h0000;
      dev_set[1] <= 16'h0000;
      shift_set[0] <= 4'h0;
      shift_set[1] <= 4'h0;
      steps_set[0] <= 20'h00000;
      steps_set[1] <= 20'h00000;
      dual_en <= 1'b0;
      fsk_en <= 1'b0;
    end
    else
    begin
      if (wr_dev)
      begin
        dev_set[dsel] <= wb_dat_i[`FRS_DEV_MSB:`FRS_DEV_LSB];
        shift_set[dsel] <= wb_dat_i[`FRS_SHIFT_MSB:`FRS_SHIFT_LSB];
        dual_en <= wb_dat_i[`FRS_DUAL_BIT];
        fsk_en <= wb_dat_i[`FRS_FSK_BIT];
      end
      if (wr_step)
        steps_set[dsel] <= wb_dat_i[`FRS_STEPS_MSB:`FRS_STEPS_LSB];
    end
  end

  // Transmit pin synchroniser
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      tx_meta <= 1'b0;
      tx_sync <= 1'b0;
    end
    else
    begin
      tx_meta <= tx_data_i;
      tx_sync <= tx_meta;
    end
  end

  // Ramp sequencer
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state <= frs_pkg::FRS_IDLE;
      ramp_val <= 37'h0000000000;
      start_val <= 37'h0000000000;
      step_cnt <= 20'h00000;
      delay_cnt <= 12'h000;
      cur_set <= 1'b0;
    end
    else if (!ramp_on || wr_start)
    begin
      // Each start-word write reloads the base value and restarts
      state <= frs_pkg::FRS_IDLE;
      ramp_val <= load_val;
      start_val <= load_val;
      step_cnt <= 20'h00000;
      delay_cnt <= 12'h000;
      cur_set <= 1'b0;
    end
    else
    begin
      case (state)
        frs_pkg::FRS_IDLE:
          state <= dly_en ? frs_pkg::FRS_DELAY : frs_pkg::FRS_UP;
        frs_pkg::FRS_DELAY:
          if (delay_cnt >= dly_word)
            state <= frs_pkg::FRS_UP;
          else if (dly_unit)
            delay_cnt <= delay_cnt + 12'h001;
        frs_pkg::FRS_UP:
          if (tick)
          begin
            if (step_cnt >= step_lim)
            begin
              // Step count already met (zero steps) or sawtooth wrap tick
              step_cnt <= 20'h00000;
              case (wave)
                frs_pkg::FRS_WAVE_SAW_CONT:
                  ramp_val <= start_val;
                frs_pkg::FRS_WAVE_SAW_ONE:
                begin
                  ramp_val <= start_val;
                  state <= frs_pkg::FRS_HOLD;
                end
                default:
                  state <= frs_pkg::FRS_HOLD;
              endcase
            end
            else
            begin
              ramp_val <= ramp_val + step_amt;
              step_cnt <= step_cnt + 20'h00001;
              if (last_step)
              begin
                case (wave)
                  frs_pkg::FRS_WAVE_RAMP_ONE:
                    state <= frs_pkg::FRS_HOLD;
                  frs_pkg::FRS_WAVE_TRI_CONT:
                  begin
                    state <= frs_pkg::FRS_DOWN;
                    step_cnt <= 20'h00000;
                  end
                  default: ; // Sawtooth: wrap on next tick
                endcase
              end
            end
          end
        frs_pkg::FRS_DOWN:
          if (tick)
          begin
            ramp_val <= ramp_val - step_amt;
            step_cnt <= step_cnt + 20'h00001;
            if (last_step)
            begin
              step_cnt <= 20'h00000;
              cur_set <= ~cur_set;
              state <= frs_pkg::FRS_UP;
            end
          end
        frs_pkg::FRS_HOLD: ;
        default:
          state <= frs_pkg::FRS_IDLE;
      endcase
    end
  end

  // Registered outputs
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      divider_o <= 37'h0000000000;
      ramp_busy_o <= 1'b0;
    end
    else
    begin
      divider_o <= next_divider;
      ramp_busy_o <= seq_run && (state != frs_pkg::FRS_HOLD);
    end
  end

  // Assertions
  frs_up_step_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (state == frs_pkg::FRS_UP && tick && ramp_on && !wr_start && step_cnt < step_lim)
      |=> ramp_val == $past(ramp_val) + $past(step_amt))
    else $error("ramp up step wrong");
  frs_hold_val_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (state == frs_pkg::FRS_HOLD && ramp_on && !wr_start) |=> $stable(ramp_val))
    else $error("held value moved");
  frs_down_step_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (state == frs_pkg::FRS_DOWN && tick && ramp_on && !wr_start)
      |=> ramp_val == $past(ramp_val) - $past(step_amt))
    else $error("ramp down step wrong");
  frs_saw_wrap_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (state == frs_pkg::FRS_UP && tick && ramp_on && !wr_start && step_cnt >= step_lim
      && wave == frs_pkg::FRS_WAVE_SAW_ONE)
      |=> ramp_val == start_val && state == frs_pkg::FRS_HOLD)
    else $error("sawtooth did not restore");
  frs_off_idle_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !ramp_on |=> state == frs_pkg::FRS_IDLE)
    else $error("ramp ran while disabled");
  frs_tri_turn_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (state == frs_pkg::FRS_DOWN && tick && last_step && ramp_on && !wr_start)
      |=> state == frs_pkg::FRS_UP && step_cnt == 20'h00000)
    else $error("triangle did not turn");
  frs_fsk_out_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (fsk_en && tx_sync) |=> divider_o == $past(ramp_val) + $past(fsk_amt))
    else $error("fsk plus offset wrong");
  frs_set_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_step |=> steps_set[$past(dsel)] == $past(wb_dat_i[`FRS_STEPS_MSB:`FRS_STEPS_LSB]))
    else $error("step set not stored");
  frs_delay_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (state == frs_pkg::FRS_DELAY && delay_cnt < dly_word && ramp_on && !wr_start)
      |=> state == frs_pkg::FRS_DELAY)
    else $error("delay ended early");
endmodule // frs_ramp_seq
`default_nettype wire

// ===== shared/frs_regs.svh
// Register offsets, field positions and widths of the ramp sequencer
`ifndef FRS_REGS_SVH
`define FRS_REGS_SVH
// Word indices (byte address = index * 4)
`define FRS_IDX_FRAC_INT 3'h0
`define FRS_IDX_LOW_FRAC 3'h1
`define FRS_IDX_REF_DIV 3'h2
`define FRS_IDX_FUNCTION 3'h3
`define FRS_IDX_CLOCK 3'h4
`define FRS_IDX_DEVIATION 3'h5
`define FRS_IDX_STEP 3'h6
`define FRS_IDX_DELAY 3'h7
`define FRS_IDX_STATUS 4'h8
// Field positions
`define FRS_RAMP_ON_BIT 31
`define FRS_INT_MSB 26
`define FRS_INT_LSB 15
`define FRS_FMSB_MSB 14
`define FRS_FMSB_LSB 3
`define FRS_FLSB_MSB 15
`define FRS_FLSB_LSB 3
`define FRS_FIRST_TIMER_DIVIDER_MSB 14
`define FRS_FIRST_TIMER_DIVIDER_LSB 3
`define FRS_SECOND_TIMER_DIVIDER_MSB 18
`define FRS_SECOND_TIMER_DIVIDER_LSB 7
`define FRS_CLKSEL_MSB 20
`define FRS_CLKSEL_LSB 19
`define FRS_CLKSEL_RAMP 2'h3
`define FRS_WAVE_MSB 11
`define FRS_WAVE_LSB 10
`define FRS_DEV_MSB 18
`define FRS_DEV_LSB 3
`define FRS_SHIFT_MSB 22
`define FRS_SHIFT_LSB 19
`define FRS_SET_SEL_BIT 23
`define FRS_DUAL_BIT 24
`define FRS_FSK_BIT 25
`define FRS_STEPS_MSB 22
`define FRS_STEPS_LSB 3
`define FRS_DLY_MSB 14
`define FRS_DLY_LSB 3
`define FRS_DLY_EN_BIT 15
`define FRS_DLY_FIRST_TIMER_DIVIDER_BIT 16
// Widths
`define FRS_FRAC_BITS 25
`define FRS_DIV_BITS 37
`endif

// ===== shared/frs_pkg.sv
// Types of the ramp sequencer
package frs_pkg;
  // Waveform type field encoding
  typedef enum logic [1:0] {
    FRS_WAVE_SAW_CONT = 2'h0,
    FRS_WAVE_TRI_CONT = 2'h1,
    FRS_WAVE_SAW_ONE = 2'h2,
    FRS_WAVE_RAMP_ONE = 2'h3
  } frs_wave_t;
  // Sequencer phase
  typedef enum logic [2:0] {
    FRS_IDLE,
    FRS_DELAY,
    FRS_UP,
    FRS_DOWN,
    FRS_HOLD
  } frs_state_t;
endpackage

// ===== src/frs_timer.sv
// Two-stage ramp timer producing one tick per first*second divider cycles
`timescale 1ns/1ps
`default_nettype none
module frs_timer
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Control
  input wire logic run_i,
  input wire logic [11:0] first_div_i,
  input wire logic [11:0] second_div_i,
  // Ticks
  output logic first_tick_o,
  output logic tick_o
);
  logic [11:0] cnt1;
  logic [11:0] cnt2;
  wire logic wrap1;
  wire logic wrap2;
  // Zero divider treated as one so the timer never stalls
  assign wrap1 = (cnt1 + 12'h001 >= first_div_i);
  assign wrap2 = (cnt2 + 12'h001 >= second_div_i);

  // Stage counters, interval = first * second cycles
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !run_i)
    begin
      cnt1 <= 12'h000;
      cnt2 <= 12'h000;
      first_tick_o <= 1'b0;
      tick_o <= 1'b0;
    end
    else
    begin
      cnt1 <= wrap1 ? 12'h000 : cnt1 + 12'h001;
      first_tick_o <= wrap1;
      tick_o <= wrap1 && wrap2;
      if (wrap1)
        cnt2 <= wrap2 ? 12'h000 : cnt2 + 12'h001;
    end
  end
endmodule // frs_timer
`default_nettype wire

// ===== tb/frs_sd_model.sv
// Behavioural sigma-delta divider that consumes the ramp word
`timescale 1ns/1ps
`default_nettype none
module frs_sd_model
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Ramp word from the sequencer
  input wire logic [36:0] divider_i,
  // Ratio in use: int plus frac over 2^25
  output logic [11:0] n_int_o,
  output logic [24:0] n_frac_o
);
  // Takes the word each reference cycle; fraction is 25 bits wide
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      n_int_o <= 12'h000;
      n_frac_o <= 25'h0000000;
    end
    else
    begin
      n_int_o <= divider_i[36:25];
      n_frac_o <= divider_i[24:0];
    end
  end
endmodule // frs_sd_model
`default_nettype wire

// ===== tb/testbench.sv
// Self-checking testbench of the ramp sequencer
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [5:0] adr = 6'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic tx = 1'b1;
  logic [31:0] rdat;
  logic ack;
  logic [36:0] divider;
  logic busy;
  logic [11:0] n_int;
  logic [24:0] n_frac;
  logic [36:0] last = 37'h0;
  logic [36:0] eq[$];
  int gq[$];
  logic [31:0] rq[$];
  logic watch = 1'b0;
  int gap = 0;
  int n_fail = 0;
  int checks = 0;
  logic [31:0] seed = 32'hb65e;
  int sq [4][7] = '{'{0, 1, 2, 0, 1, 2, 0}, '{0, 1, 2, 1, 0, 1, 2},
    '{0, 1, 2, 0, 0, 0, 0}, '{0, 1, 2, 0, 0, 0, 0}};
  int ln [4] = '{7, 7, 4, 3};

  always #5 clk_i = ~clk_i;

  frs_ramp_seq i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .tx_data_i(tx), .divider_o(divider), .ramp_busy_o(busy));
  frs_sd_model i_sd (.clk_i(clk_i), .rst_i(rst_i), .divider_i(divider),
    .n_int_o(n_int), .n_frac_o(n_frac));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Flags are fsk, dual, set select
  function automatic logic [31:0] devw(input logic [2:0] fl, input logic [3:0] sh,
    input logic [15:0] d);
    return {6'h00, fl, sh, d, 3'h0};
  endfunction
  function automatic logic [31:0] stw(input logic [19:0] n);
    return {9'h000, n, 3'h0};
  endfunction

  task automatic check(input string what, input logic [63:0] got, input logic [63:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Classic cycle: hold everything until ack is sampled high
  task automatic wb(input logic w, input logic [3:0] idx, input logic [3:0] s,
    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    sel <= s;
    wdat <= d;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack !== 1'b1 && n < 40);
    if (n >= 40)
      n_fail++;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] idx, input logic [31:0] e);
    rq.push_back(e);
    wb(1'b0, idx, 4'hf, 32'h0);
  endtask

  task automatic ex(input logic [36:0] v, input int g);
    eq.push_back(v);
    gq.push_back(g);
  endtask

  // Stop, then the full word sequence, start word left to the caller
  task automatic cfg(input logic [1:0] wv, input logic [31:0] s1, input logic [31:0] s2,
    input logic [31:0] d1, input logic [31:0] d2, input logic [12:0] fl,
    input logic [31:0] dl);
    watch = 1'b0;
    wb(1'b1, 4'h0, 4'hf, 32'h0);
    wb(1'b1, 4'h7, 4'hf, dl);
    wb(1'b1, 4'h6, 4'hf, s1);
    wb(1'b1, 4'h6, 4'hf, s2 | 32'h0080_0000);
    wb(1'b1, 4'h5, 4'hf, d1);
    wb(1'b1, 4'h5, 4'hf, d2);
    wb(1'b1, 4'h4, 4'hf, {11'h000, 2'h3, 12'h002, 7'h00});
    wb(1'b1, 4'h3, 4'hf, {20'h00000, wv, 10'h000});
    wb(1'b1, 4'h2, 4'hf, {17'h00000, 12'h003, 3'h0});
    wb(1'b1, 4'h1, 4'hf, {16'h0000, fl, 3'h0});
    // New fraction needs four edges to reach the divider model
    repeat (6) @(posedge clk_i);
    watch = 1'b1;
  endtask

  task automatic go(input logic [11:0] iv);
    wb(1'b1, 4'h0, 4'hf, {1'b1, 4'h0, iv, 15'h0000});
  endtask

  // Waits until every noted value has shown up
  task automatic drain;
    int n;
    n = 0;
    while (eq.size() > 0 && n < 400)
    begin
      @(posedge clk_i);
      n++;
    end
    check("pending values", eq.size(), 0);
    eq.delete();
    gq.delete();
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Scoreboard: oldest note against each read and each ratio change
  always @(posedge clk_i)
  begin
    gap++;
    if (ack === 1'b1 && we === 1'b0 && rq.size() > 0)
      check("read data", rdat, rq.pop_front());
    if (watch && {n_int, n_frac} !== last)
    begin
      if (eq.size() == 0)
        check("unexpected step", {n_int, n_frac}, last);
      else
      begin
        check("divider", {n_int, n_frac}, eq.pop_front());
        if (gq[0] != 0)
          check("interval", gap, gq[0]);
        void'(gq.pop_front());
      end
    end
    if ({n_int, n_frac} !== last)
      gap = 0;
    last = {n_int, n_frac};
  end

  // Watchdog well beyond the expected several hundred cycles
  initial
  begin
    repeat (20000) @(posedge clk_i);
    n_fail++;
    results();
  end

  initial
  begin
    logic [15:0] dv;
    logic [3:0] sh;
    logic [36:0] d;
    logic [36:0] b;
    logic [36:0] f;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(4'h8, 32'h0);
    rd(4'hd, 32'h0);
    wb(1'b1, 4'h0, 4'h3, 32'h8000_0000);
    repeat (4) @(posedge clk_i);
    check("busy after partial write", busy, 1'b0);
    $display("test registers done");
    // Each waveform code, random deviation and offset
    for (int m = 0; m < 4; m++)
    begin
      seed = lfsr(seed);
      dv = {4'h0, seed[11:0]} + 16'h0001;
      sh = {1'b0, seed[14:12]};
      d = 37'(dv) << sh;
      b = {12'(100 + m), 12'h000, seed[28:16]};
      cfg(m[1:0], stw(20'h2), stw(20'h2), devw(3'b000, sh, dv), devw(3'b001, sh, dv),
        seed[28:16], 32'h0);
      for (int k = 0; k < ln[m]; k++)
        ex(b + 37'(sq[m][k]) * d, (k < 2) ? 0 : 6);
      go(12'(100 + m));
      drain();
      // Continuous modes keep stepping; only the single ones must stay put
      if (m < 2)
        watch = 1'b0;
      repeat (20) @(posedge clk_i);
      check("busy", busy, (m < 2) ? 1'b1 : 1'b0);
      $display("test waveform %0d done", m);
    end
    // Dual rates, second set rewritten while the first runs
    d = 37'(16'h0123) << 2;
    f = 37'(16'h0051) << 1;
    b = {12'h0c8, 25'h0};
    cfg(2'h1, stw(20'h2), stw(20'h1), devw(3'b010, 4'h2, 16'h0123),
      devw(3'b011, 4'h1, 16'h7fff), 13'h0, 32'h0);
    ex(b, 0);
    ex(b + d, 0);
    ex(b + 2 * d, 6);
    ex(b + d, 6);
    ex(b, 6);
    ex(b + f, 6);
    ex(b, 6);
    go(12'h0c8);
    wb(1'b1, 4'h5, 4'hf, devw(3'b011, 4'h1, 16'h0051));
    drain();
    $display("test dual rates done");
    // Ramp with keyed deviation on top, after a delayed start
    d = 37'(16'h0040) << 3;
    f = 37'(16'h0011);
    b = {12'h0d0, 25'h0};
    cfg(2'h3, stw(20'h1), stw(20'h1), devw(3'b100, 4'h3, 16'h0040),
      devw(3'b101, 4'h0, 16'h0011), 13'h0, {16'h0000, 1'b1, 12'h028, 3'h0});
    ex(b + f, 0);
    ex(b + d + f, 0);
    go(12'h0d0);
    drain();
    ex(b + d - f, 0);
    tx <= 1'b0;
    drain();
    ex(b + d + f, 0);
    tx <= 1'b1;
    drain();
    $display("test keyed deviation done");
    results();
  end
endmodule // testbench
`default_nettype wire
